// ==== bbd_pkg.sv ====
/*
 * constants for the boot read mover and queue doorbell register block:
 * register offsets, field positions, status codes, sizes and state codes.
 * assumes byte addressing on a 16-bit register address with 32-bit words.
 */
package bbd_pkg;
    // register byte offsets
    localparam logic [15:0] OFS_BOOT_READ_SELECT = 16'h0044;
    localparam logic [15:0] OFS_BUF_LOC_LO       = 16'h0048;
    localparam logic [15:0] OFS_BUF_LOC_HI       = 16'h004c;
    localparam logic [15:0] OFS_DOORBELL_BASE    = 16'h1000;

    // boot_read_select fields
    localparam int SEL_PART_BIT = 31;
    localparam int SEL_OFS_MSB  = 29;
    localparam int SEL_OFS_LSB  = 10;
    localparam int SEL_SIZE_MSB = 9;
    localparam int SEL_SIZE_LSB = 0;

    // buffer location fields
    localparam int LOC_BASE_W   = 52;
    localparam int LOC_RSVD_W   = 12;
    localparam int LOC_LO_BASEW = 20;

    // doorbell pointer field
    localparam int DB_PTR_W = 16;

    // granules: 4KB slice = 1024 words, 128KB partition unit = 32 slices
    localparam int SLICE_WORD_SHIFT = 10;
    localparam int PSZ_SLICE_SHIFT  = 5;
    localparam int PSZ_W            = 15;
    localparam int WORD_CNT_W       = 20;
    localparam int PART_ADDR_W      = 30;

    // queues
    localparam int NQ  = 4;
    localparam int QID_W = 2;
    localparam int STRIDE_W = 4;
    localparam logic [4:0] DB_MIN_SHIFT = 5'd2;

    // boot read status codes
    localparam logic [1:0] BRS_NONE  = 2'b00;
    localparam logic [1:0] BRS_BUSY  = 2'b01;
    localparam logic [1:0] BRS_DONE  = 2'b10;
    localparam logic [1:0] BRS_ERROR = 2'b11;

    // buffer entry: host address plus data word
    localparam int BUF_W = 96;

    typedef enum logic [1:0] {
        BBD_IDLE  = 2'b00,
        BBD_CHECK = 2'b01,
        BBD_FETCH = 2'b10,
        BBD_PUSH  = 2'b11
    } bbd_mover_t;
endpackage

// ==== bbd_buf_if.sv ====
/*
 * valid/ready carrier between the mover and its two-entry buffer.
 * assumes a single clock shared by both ends.
 */
`timescale 1ns/1ps
`default_nettype none
interface bbd_buf_if;
    logic                      valid;
    logic                      ready;
    logic [bbd_pkg::BUF_W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== bbd_skid_buf.sv ====
/*
 * two-entry buffer between the boot read mover and the host write port.
 * assumes a synchronous active-high reset and one clock.
 */
`timescale 1ns/1ps
`default_nettype none
module bbd_skid_buf (
    // clock and reset
    input  wire logic                      i_mclk,
    input  wire logic                      i_srst,
    // fill side
    bbd_buf_if.snk                         in_if,
    // drain side
    output var  logic                      o_valid,
    output var  logic [bbd_pkg::BUF_W-1:0] o_data,
    input  wire logic                      i_ready
);
    typedef struct packed {
        logic [1:0][bbd_pkg::BUF_W-1:0] mem;
        logic                           rd_ptr;
        logic                           wr_ptr;
        logic [1:0]                     count;
    } bbd_buf_state_t;

    bbd_buf_state_t q;
    bbd_buf_state_t d;
    logic           push;
    logic           pop;

    assign in_if.ready = (q.count != 2'd2);
    assign o_valid     = (q.count != 2'd0);
    assign o_data      = q.mem[q.rd_ptr];

    always_comb begin
        d    = q;
        push = in_if.valid && (q.count != 2'd2);
        pop  = i_ready && (q.count != 2'd0);
        if (push) begin
            d.mem[q.wr_ptr] = in_if.data;
            d.wr_ptr        = ~q.wr_ptr;
        end
        if (pop) begin
            d.rd_ptr = ~q.rd_ptr;
        end
        d.count = q.count + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

// ==== bbd_boot_doorbell.sv ====
/*
 * boot partition read select, boot buffer location, boot read mover and
 * per-queue tail/head doorbells behind a plain memory-mapped register port.
 * assumes one write or read per cycle, full 32-bit writes, and a partition
 * store that returns i_part_rdata one cycle after o_part_addr settles and
 * holds it while the address stays put.
 */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - without boot support, select and buffer location read zero
// - offset plus size past partition end: no data moved, error status
// - select bit 31 picks the partition, read-write, resets zero
// - bits 29:10 give start offset in 4KB units
// - bits 9:0 give transfer length in 4KB units
// - buffer location 63:12 is the base, 11:0 read zero, host aligns it
// - tail doorbell y at 1000h + 2y*(4<<stride)
// - head doorbell y at 1000h + (2y+1)*(4<<stride)
// - doorbell reads return an arbitrary value, here zero
// - tail write replaces stored tail; bits 31:16 read zero
// - head write replaces stored head; wrapped distance is slots freed
// - select write starts read; status 00 none, 01 busy, 10 done, 11 error
// - bounds use 15-bit partition size, same for both partitions
module bbd_boot_doorbell (
    // clock and reset
    input  wire logic                                    i_mclk,
    input  wire logic                                    i_srst,
    // register port
    input  wire logic                                    i_reg_wr,
    input  wire logic                                    i_reg_rd,
    input  wire logic [15:0]                             i_reg_addr,
    input  wire logic [31:0]                             i_reg_wdata,
    output var  logic [31:0]                             o_reg_rdata,
    output var  logic                                    o_reg_rvalid,
    // configuration
    input  wire logic                                    i_boot_supported,
    input  wire logic [bbd_pkg::PSZ_W-1:0]               i_partition_size,
    input  wire logic [bbd_pkg::STRIDE_W-1:0]            i_doorbell_stride,
    input  wire logic [bbd_pkg::NQ-1:0][15:0]            i_sq_entries,
    input  wire logic [bbd_pkg::NQ-1:0][15:0]            i_cq_entries,
    // boot status
    output var  logic [1:0]                              o_boot_read_status,
    // partition store
    output var  logic                                    o_part_sel,
    output var  logic [bbd_pkg::PART_ADDR_W-1:0]         o_part_addr,
    input  wire logic [31:0]                             i_part_rdata,
    // host memory writes
    output var  logic                                    o_hwr_valid,
    output var  logic [63:0]                             o_hwr_addr,
    output var  logic [31:0]                             o_hwr_data,
    input  wire logic                                    i_hwr_ready,
    // doorbell events
    output var  logic                                    o_db_valid,
    output var  logic                                    o_db_is_head,
    output var  logic [bbd_pkg::QID_W-1:0]               o_db_qid,
    output var  logic [15:0]                             o_db_count
);
    typedef struct packed {
        logic                                       part_sel;
        logic [bbd_pkg::SEL_OFS_MSB-bbd_pkg::SEL_OFS_LSB:0] read_offset_4k;
        logic [bbd_pkg::SEL_SIZE_MSB:0]             read_size_4k;
        logic [bbd_pkg::LOC_BASE_W-1:0]             buffer_base_address;
        logic [1:0]                                 boot_read_status;
        bbd_pkg::bbd_mover_t                        mover;
        logic [bbd_pkg::WORD_CNT_W-1:0]             word_cnt;
        logic [bbd_pkg::PART_ADDR_W-1:0]            part_addr;
        logic [63:0]                                host_addr;
        logic [bbd_pkg::NQ-1:0][15:0]               submit_tail_value;
        logic [bbd_pkg::NQ-1:0][15:0]               complete_head_value;
        logic [31:0]                                rdata;
        logic                                       rvalid;
        logic                                       db_valid;
        logic                                       db_is_head;
        logic [bbd_pkg::QID_W-1:0]                  db_qid;
        logic [15:0]                                db_count;
    } bbd_state_t;

    bbd_state_t                 q;
    bbd_state_t                 d;
    logic [15:0]                db_off;
    logic                       db_wr;
    logic [bbd_pkg::NQ-1:0]     sq_hit;
    logic [bbd_pkg::NQ-1:0]     cq_hit;
    logic [4:0]                 db_shift;
    logic [20:0]                read_end;
    logic [19:0]                part_slices;
    logic [bbd_pkg::WORD_CNT_W-1:0] total_words;

    bbd_buf_if buf_if ();

    // wrapped forward distance from old to new pointer in a ring of size entries
    function automatic logic [15:0] wrap_dist(input logic [15:0] nxt,
                                              input logic [15:0] old,
                                              input logic [15:0] entries);
        logic [16:0] t;
        t = 17'h0_0000;
        if (nxt >= old) begin
            t = {1'b0, nxt} - {1'b0, old};
        end else begin
            t = {1'b0, nxt} + {1'b0, entries} - {1'b0, old};
        end
        return t[15:0];
    endfunction

    assign db_wr    = i_reg_wr && (i_reg_addr >= bbd_pkg::OFS_DOORBELL_BASE);
    assign db_off   = i_reg_addr - bbd_pkg::OFS_DOORBELL_BASE;
    assign db_shift = {1'b0, i_doorbell_stride} + bbd_pkg::DB_MIN_SHIFT;

    genvar gq;
    generate
        for (gq = 0; gq < bbd_pkg::NQ; gq++) begin : g_queue
            // shifts past the 16-bit window truncate; such doorbells alias onto lower offsets, down to zero
            assign sq_hit[gq] = db_wr && (db_off == (16'(2 * gq) << db_shift));
            assign cq_hit[gq] = db_wr && (db_off == (16'(2 * gq + 1) << db_shift));
        end
    endgenerate

    // end of read and partition size, both in 4KB slices
    assign read_end    = {1'b0, q.read_offset_4k} + 21'(q.read_size_4k);
    assign part_slices = {i_partition_size, 5'h00};
    assign total_words = {q.read_size_4k, 10'h000};

    always_comb begin
        d          = q;
        d.rvalid   = i_reg_rd;
        d.rdata    = 32'h0000_0000;
        d.db_valid = 1'b0;

        // register reads; doorbells and unmapped offsets return zero
        if (i_reg_rd && i_boot_supported) begin
            case (i_reg_addr)
                bbd_pkg::OFS_BOOT_READ_SELECT: begin
                    d.rdata = {q.part_sel, 1'b0, q.read_offset_4k, q.read_size_4k};
                end
                bbd_pkg::OFS_BUF_LOC_LO: begin
                    d.rdata = {q.buffer_base_address[bbd_pkg::LOC_LO_BASEW-1:0],
                               12'h000};
                end
                bbd_pkg::OFS_BUF_LOC_HI: begin
                    d.rdata = q.buffer_base_address[bbd_pkg::LOC_BASE_W-1:
                                                    bbd_pkg::LOC_LO_BASEW];
                end
                default: begin
                    d.rdata = 32'h0000_0000;
                end
            endcase
        end

        // boot register writes; select is locked while a read runs
        if (i_reg_wr && i_boot_supported) begin
            if (i_reg_addr == bbd_pkg::OFS_BOOT_READ_SELECT &&
                q.mover == bbd_pkg::BBD_IDLE) begin
                d.part_sel       = i_reg_wdata[bbd_pkg::SEL_PART_BIT];
                d.read_offset_4k = i_reg_wdata[bbd_pkg::SEL_OFS_MSB:bbd_pkg::SEL_OFS_LSB];
                d.read_size_4k   = i_reg_wdata[bbd_pkg::SEL_SIZE_MSB:bbd_pkg::SEL_SIZE_LSB];
                d.boot_read_status = bbd_pkg::BRS_BUSY;
                d.mover          = bbd_pkg::BBD_CHECK;
            end
            if (i_reg_addr == bbd_pkg::OFS_BUF_LOC_LO) begin
                d.buffer_base_address[bbd_pkg::LOC_LO_BASEW-1:0] =
                    i_reg_wdata[31:bbd_pkg::LOC_RSVD_W];
            end
            if (i_reg_addr == bbd_pkg::OFS_BUF_LOC_HI) begin
                d.buffer_base_address[bbd_pkg::LOC_BASE_W-1:bbd_pkg::LOC_LO_BASEW] =
                    i_reg_wdata;
            end
        end

        // boot read mover
        case (q.mover)
            bbd_pkg::BBD_IDLE: begin
            end
            bbd_pkg::BBD_CHECK: begin
                d.word_cnt  = '0;
                d.part_addr = {q.read_offset_4k, 10'h000};
                d.host_addr = {q.buffer_base_address, 12'h000};
                if (read_end > {1'b0, part_slices}) begin
                    d.boot_read_status = bbd_pkg::BRS_ERROR;
                    d.mover            = bbd_pkg::BBD_IDLE;
                end else if (q.read_size_4k == '0) begin
                    d.boot_read_status = bbd_pkg::BRS_DONE;
                    d.mover            = bbd_pkg::BBD_IDLE;
                end else begin
                    d.mover = bbd_pkg::BBD_FETCH;
                end
            end
            bbd_pkg::BBD_FETCH: begin
                // address settles here, data is taken next cycle
                d.mover = bbd_pkg::BBD_PUSH;
            end
            bbd_pkg::BBD_PUSH: begin
                if (buf_if.ready) begin
                    if (q.word_cnt == total_words - 20'h0_0001) begin
                        d.boot_read_status = bbd_pkg::BRS_DONE;
                        d.mover            = bbd_pkg::BBD_IDLE;
                    end else begin
                        d.word_cnt  = q.word_cnt + 20'h0_0001;
                        d.part_addr = q.part_addr + 30'h0000_0001;
                        d.host_addr = q.host_addr + 64'h0000_0000_0000_0004;
                        d.mover     = bbd_pkg::BBD_FETCH;
                    end
                end
            end
            default: begin
                d.mover = bbd_pkg::BBD_IDLE;
            end
        endcase

        // doorbell writes; at most one hits per cycle for strides below 12, above that the last hit sets the event
        for (int i = 0; i < bbd_pkg::NQ; i++) begin
            if (sq_hit[i]) begin
                d.submit_tail_value[i] = i_reg_wdata[bbd_pkg::DB_PTR_W-1:0];
                d.db_valid   = 1'b1;
                d.db_is_head = 1'b0;
                d.db_qid     = bbd_pkg::QID_W'(i);
                d.db_count   = wrap_dist(i_reg_wdata[15:0], q.submit_tail_value[i],
                                         i_sq_entries[i]);
            end
            if (cq_hit[i]) begin
                d.complete_head_value[i] = i_reg_wdata[bbd_pkg::DB_PTR_W-1:0];
                d.db_valid   = 1'b1;
                d.db_is_head = 1'b1;
                d.db_qid     = bbd_pkg::QID_W'(i);
                d.db_count   = wrap_dist(i_reg_wdata[15:0], q.complete_head_value[i],
                                         i_cq_entries[i]);
            end
        end
    end

    // all pointers and boot fields start at zero
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign buf_if.valid = (q.mover == bbd_pkg::BBD_PUSH);
    assign buf_if.data  = {q.host_addr, i_part_rdata};

    bbd_skid_buf u_buf (
        .i_mclk  (i_mclk),
        .i_srst  (i_srst),
        .in_if   (buf_if),
        .o_valid (o_hwr_valid),
        .o_data  ({o_hwr_addr, o_hwr_data}),
        .i_ready (i_hwr_ready)
    );

    assign o_reg_rdata        = q.rdata;
    assign o_reg_rvalid       = q.rvalid;
    assign o_boot_read_status = q.boot_read_status;
    assign o_part_sel         = q.part_sel;
    assign o_part_addr        = q.part_addr;
    assign o_db_valid         = q.db_valid;
    assign o_db_is_head       = q.db_is_head;
    assign o_db_qid           = q.db_qid;
    assign o_db_count         = q.db_count;
endmodule
`default_nettype wire

// ==== bbd_boot_doorbell_sva.sv ====
/*
 * port assertions for the boot read and doorbell register block.
 * assumes a bind onto bbd_boot_doorbell, one clock, sync active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module bbd_boot_doorbell_sva (
    // clock and reset
    input wire logic                      i_mclk,
    input wire logic                      i_srst,
    // register port
    input wire logic                      i_reg_wr,
    input wire logic                      i_reg_rd,
    input wire logic [15:0]               i_reg_addr,
    input wire logic [31:0]               o_reg_rdata,
    input wire logic                      o_reg_rvalid,
    input wire logic                      i_boot_supported,
    // boot mover
    input wire logic [1:0]                o_boot_read_status,
    input wire logic                      o_hwr_valid,
    input wire logic [63:0]               o_hwr_addr,
    input wire logic [31:0]               o_hwr_data,
    input wire logic                      i_hwr_ready,
    // doorbells
    input wire logic                      o_db_valid,
    input wire logic                      o_db_is_head,
    input wire logic [bbd_pkg::QID_W-1:0] o_db_qid
);
    // remembers reset so the first edge after release is still checked
    logic rst_q;
    always_ff @(posedge i_mclk) rst_q <= i_srst;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    reset_clear_a: assert property (rst_q |-> o_boot_read_status == 2'h0 && !o_hwr_valid && !o_db_valid)
        else $error("outputs not clear after reset");
    read_answer_a: assert property (i_reg_rd |=> o_reg_rvalid ##1 !o_reg_rvalid || $past(i_reg_rd))
        else $error("read answer not one cycle after strobe");
    idle_rdata_a: assert property (!o_reg_rvalid |-> o_reg_rdata == 32'h0)
        else $error("read data not zero while idle");
    db_read_zero_a: assert property (i_reg_rd && i_reg_addr[15:12] == 4'h1 |=> o_reg_rdata == 32'h0)
        else $error("doorbell read not zero");
    unsup_zero_a: assert property (i_reg_rd && !i_boot_supported && i_reg_addr[15:4] == 12'h004 |=> o_reg_rdata == 32'h0)
        else $error("boot register nonzero without support");
    loc_rsvd_a: assert property (i_reg_rd && i_reg_addr == 16'h0048 |=> o_reg_rdata[11:0] == 12'h0)
        else $error("buffer location low bits not zero");
    sel_rsvd_a: assert property (i_reg_rd && i_reg_addr == 16'h0044 |=> o_reg_rdata[30] == 1'b0)
        else $error("select bit 30 not zero");
    start_busy_a: assert property (i_reg_wr && i_reg_addr == 16'h0044 && i_boot_supported
        && o_boot_read_status != 2'b01 |=> o_boot_read_status == 2'b01)
        else $error("select write did not start a read");
    err_no_move_a: assert property (o_boot_read_status == 2'b11 |-> !o_hwr_valid)
        else $error("host write during error status");
    stall_hold_a: assert property (o_hwr_valid && !i_hwr_ready
        |=> o_hwr_valid && $stable(o_hwr_addr) && $stable(o_hwr_data))
        else $error("host word changed during stall");
    tail0_decode_a: assert property (i_reg_wr && i_reg_addr == 16'h1000
        |=> o_db_valid && !o_db_is_head && o_db_qid == '0)
        else $error("queue 0 tail doorbell missed");
    db_cause_a: assert property (o_db_valid |-> $past(i_reg_wr) && $past(i_reg_addr) >= 16'h1000)
        else $error("doorbell event without doorbell write");
endmodule
bind bbd_boot_doorbell bbd_boot_doorbell_sva bbd_boot_doorbell_sva_i (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .i_boot_supported(i_boot_supported), .o_boot_read_status(o_boot_read_status),
    .o_hwr_valid(o_hwr_valid), .o_hwr_addr(o_hwr_addr), .o_hwr_data(o_hwr_data),
    .i_hwr_ready(i_hwr_ready), .o_db_valid(o_db_valid), .o_db_is_head(o_db_is_head),
    .o_db_qid(o_db_qid));
`default_nettype wire

// ==== bbd_host_model.sv ====
/*
 * far side model: partition store with one-cycle read latency and a host
 * memory sink that can stall. assumes the block's single clock.
 */
`timescale 1ns/1ps
`default_nettype none
module bbd_host_model (
    // clock
    input  wire logic        i_mclk,
    // partition store
    input  wire logic        i_part_sel,
    input  wire logic [29:0] i_part_addr,
    output var  logic [31:0] o_part_rdata,
    // host memory sink
    input  wire logic        i_slow,
    output var  logic        o_hwr_ready
);
    logic [3:0] cnt_q = 4'h0;
    always_ff @(posedge i_mclk) begin
        // word carries its own address so order slips show up
        o_part_rdata <= {i_part_sel, 1'b0, i_part_addr};
        cnt_q <= cnt_q + 4'h1;
    end
    // slow mode stalls 8 of 16 cycles, long enough to fill the buffer
    assign o_hwr_ready = !i_slow || cnt_q[3];
endmodule
`default_nettype wire

// ==== tb_top.sv ====
/*
 * self-checking bench for the boot read and doorbell register block.
 * assumes bbd_pkg, the block, its checker and bbd_host_model are compiled.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk, srst, wr_s, rd_s, sup, slow, rvalid, psel, hv, hready, dbv, dbh, psel_e;
    logic [15:0] addr, dbc;
    logic [31:0] wdata, rdata, prdata, hdata;
    logic [1:0]  status, dbq;
    logic [29:0] paddr, pofs_e;
    logic [63:0] haddr, base_e;
    int          err_total, checks_done, words;

    bbd_boot_doorbell bbd_boot_doorbell_i (
        .i_mclk(clk), .i_srst(srst), .i_reg_wr(wr_s), .i_reg_rd(rd_s), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_boot_supported(sup), .i_partition_size(15'h0001), .i_doorbell_stride(4'h1),
        .i_sq_entries({4{16'h0008}}), .i_cq_entries({4{16'h0008}}),
        .o_boot_read_status(status), .o_part_sel(psel), .o_part_addr(paddr),
        .i_part_rdata(prdata), .o_hwr_valid(hv), .o_hwr_addr(haddr), .o_hwr_data(hdata),
        .i_hwr_ready(hready), .o_db_valid(dbv), .o_db_is_head(dbh), .o_db_qid(dbq),
        .o_db_count(dbc));
    bbd_host_model bbd_host_model_i (
        .i_mclk(clk), .i_part_sel(psel), .i_part_addr(paddr), .o_part_rdata(prdata),
        .i_slow(slow), .o_hwr_ready(hready));

    always #4 clk = ~clk;

    task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(negedge clk);
        wr_s = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr_s = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string what);
        @(negedge clk);
        rd_s = 1'b1;
        addr = a;
        @(negedge clk);
        rd_s = 1'b0;
        cmp(what, {31'h0, 1'b1, exp}, {31'h0, rvalid, rdata});
    endtask
    task automatic dbw(input logic [15:0] a, input logic [31:0] d, input logic [19:0] exp);
        wr(a, d);
        cmp("doorbell", 64'(exp), 64'({dbv, dbh, dbq, dbc}));
    endtask
    // bounded wait for the mover to finish and the buffer to drain
    task automatic wait_done(input logic [1:0] exp, input int n);
        int i;
        i = 0;
        while ((status === 2'b01 || hv !== 1'b0) && i < 20000) begin
            @(negedge clk);
            i++;
        end
        cmp("status", 64'(exp), 64'(status));
        cmp("words", 64'(n), 64'(words));
        words = 0;
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // look half a cycle before the edge that takes the word, while it stands
    always @(negedge clk) begin
        if (hv === 1'b1 && hready === 1'b1) begin
            cmp("host addr", base_e + 64'(words) * 64'd4, haddr);
            cmp("host data", {32'h0, psel_e, 1'b0, pofs_e + 30'(words)}, {32'h0, hdata});
            words++;
        end
    end

    initial begin
        repeat (30000) @(posedge clk);
        err_total++;
        results();
    end

    initial begin
        {clk, wr_s, rd_s, slow, psel_e, addr, wdata, pofs_e, base_e} = '0;
        {srst, sup} = 2'b11;
        words = 0;
        repeat (6) @(negedge clk);
        srst = 1'b0;
        rd(16'h0044, 32'h0, "select");
        rd(16'h004c, 32'h0, "loc hi");
        cmp("status", 64'h0, 64'(status));
        $display("test reset values done");
        wr(16'h0048, 32'h1234_5fff);
        wr(16'h004c, 32'h0000_00ab);
        rd(16'h0048, 32'h1234_5000, "loc lo");
        rd(16'h004c, 32'h0000_00ab, "loc hi");
        {base_e, psel_e, pofs_e, slow} = {64'h0000_00ab_1234_5000, 1'b1, 30'd31744, 1'b1};
        // last slice of partition 1, exactly at the end, host stalling
        wr(16'h0044, 32'hc000_7c01);
        cmp("status", 64'h1, 64'(status));
        wr(16'h0044, 32'h0000_0002);
        rd(16'h0044, 32'h8000_7c01, "select");
        wait_done(2'b10, 1024);
        {psel_e, pofs_e, slow} = '0;
        wr(16'h0044, 32'h0000_0001);
        wait_done(2'b10, 1024);
        wr(16'h0044, 32'h0000_7c02);
        wait_done(2'b11, 0);
        wr(16'h0044, 32'h0000_0000);
        wait_done(2'b10, 0);
        $display("test boot read done");
        for (int y = 0; y < 4; y++) begin
            dbw(16'h1000 + 16'(y * 16), 32'(y + 3), {2'b10, 2'(y), 16'(y + 3)});
            dbw(16'h1008 + 16'(y * 16), 32'(y + 1), {2'b11, 2'(y), 16'(y + 1)});
        end
        dbw(16'h1020, 32'h0000_0001, {4'b1010, 16'd4});
        dbw(16'h1018, 32'h0000_0000, {4'b1101, 16'd6});
        dbw(16'h1030, 32'hffff_0004, {4'b1011, 16'd6});
        // no hit: pulse stays low, event fields keep the queue 3 tail event
        dbw(16'h1004, 32'h0000_0009, {4'b0011, 16'd6});
        rd(16'h1010, 32'h0, "doorbell read");
        rd(16'h0100, 32'h0, "unmapped");
        $display("test doorbells done");
        sup = 1'b0;
        rd(16'h0044, 32'h0, "select");
        rd(16'h0048, 32'h0, "loc lo");
        $display("test no boot support done");
        results();
    end
endmodule
`default_nettype wire
